//--- include/scsp_regs.svh
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SCSP_OFF_CTRL        12'h000
`define SCSP_OFF_CAL         12'h004
`define SCSP_OFF_STATUS      12'h008
`define SCSP_OFF_FREQ        12'h00C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCSP_CTRL_LOOP_EN    0
`define SCSP_CTRL_T1_LO      1
`define SCSP_CTRL_T1_HI      2
`define SCSP_CTRL_MODE_LO    4
`define SCSP_CTRL_MODE_HI    6
`define SCSP_CTRL_SLEEP_GO   8

// ---------------------------------------------------------------
// Reset and factory values
// ---------------------------------------------------------------
`define SCSP_CAL_RESET       8'h80
`define SCSP_DEF_SOURCE      4'h1
`define SCSP_DEF_STARTUP     2'h2
`define SCSP_DEF_LOOP_OPT    1'b1

// ---------------------------------------------------------------
// Clock model and timing counts
// ---------------------------------------------------------------
`define SCSP_RC_BASE_KHZ     14'h0F40
`define SCSP_RC_STEP_SHIFT   5
`define SCSP_REF_DIV_SHIFT   3
`define SCSP_REF_NOM_KHZ     12'h3E8
`define SCSP_LOOP_MULT_SHIFT 6
`define SCSP_FAST_MAX_KHZ    17'h11170
`define SCSP_LOCK_CYCLES     8'h40
`define SCSP_CK_6            17'h00006
`define SCSP_CK_18           17'h00012
`define SCSP_CK_258          17'h00102
`define SCSP_CK_1K           17'h00400
`define SCSP_WDT_4K          17'h01000

`endif

//--- include/scsp_pkg.sv
package scsp_pkg;

    typedef enum logic [2:0] {
        SCSP_SRC_EXT_CLK,
        SCSP_SRC_INT_RC,
        SCSP_SRC_EXT_RC,
        SCSP_SRC_LF_XTAL,
        SCSP_SRC_XTAL,
        SCSP_SRC_LOOP
    } scsp_src_type;

    typedef enum logic [2:0] {
        SCSP_SLP_IDLE,
        SCSP_SLP_ADC_NOISE,
        SCSP_SLP_POWER_DOWN,
        SCSP_SLP_STANDBY
    } scsp_sleep_type;

    typedef enum logic [1:0] {
        SCSP_DLY_NONE,
        SCSP_DLY_SHORT,
        SCSP_DLY_LONG
    } scsp_delay_type;

    typedef enum {
        ST_LATCH,
        ST_START,
        ST_RSTDLY,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } scsp_state_type;

endpackage

//--- hdl/scsp_clock_ctrl.sv
`include "scsp_regs.svh"
module scsp_clock_ctrl #(
    parameter logic [16:0] WAKE_16K = 17'h04000,
    parameter logic [16:0] WAKE_32K = 17'h08000,
    parameter logic [16:0] WDT_64K  = 17'h10000
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [3:0]          source_select,
    input  wire logic [1:0]          startup_select,
    input  wire logic                loop_clock_option,
    input  wire logic                ext_irq_pin,
    input  wire logic                watchdog_oscillator,
    input  wire logic                src_clk_pin,
    output logic                     wake_request,
    output logic                     clk_cpu_en,
    output logic                     clk_io_en,
    output logic                     clk_flash_en,
    output logic                     clk_adc_en,
    output logic                     rc_osc_on,
    output logic                     loop_running,
    output logic                     loop_locked_flag,
    output logic      [16:0]         fast_clk_khz,
    output logic      [1:0]          timer1_clk_sel,
    output logic                     port_b_pin4_crystal,
    output logic                     port_b_pin5_crystal,
    output scsp_pkg::scsp_src_type   src_class
);
    import scsp_pkg::*;

    // ---------------------------------------------------------------
    // Option latch
    // ---------------------------------------------------------------
    logic [3:0]     src_sel_ff;
    logic [1:0]     sut_ff;
    logic           loop_opt_ff;
    logic           latched_ff;
    scsp_state_type state_ff;
    scsp_state_type nxt_state;

    // Straps are sampled by the clock after release, never by the reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_ff  <= `SCSP_DEF_SOURCE;
            sut_ff      <= `SCSP_DEF_STARTUP;
            loop_opt_ff <= `SCSP_DEF_LOOP_OPT;
            latched_ff  <= 1'b0;
        end else if (!latched_ff) begin
            src_sel_ff  <= source_select;
            sut_ff      <= startup_select;
            loop_opt_ff <= loop_clock_option;
            latched_ff  <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Source decode and start-up tables
    // ---------------------------------------------------------------
    scsp_src_type   nxt_src;
    scsp_delay_type rst_dly;
    logic [16:0]    wake_target;

    always_comb begin
        // Programmed option bit reads 0
        if (!loop_opt_ff && src_sel_ff == 4'h1) begin
            nxt_src = SCSP_SRC_LOOP;
        end else if (src_sel_ff >= 4'hA) begin
            nxt_src = SCSP_SRC_XTAL;
        end else if (src_sel_ff == 4'h9) begin
            nxt_src = SCSP_SRC_LF_XTAL;
        end else if (src_sel_ff >= 4'h5) begin
            nxt_src = SCSP_SRC_EXT_RC;
        end else if (src_sel_ff >= 4'h1) begin
            nxt_src = SCSP_SRC_INT_RC;
        end else begin
            nxt_src = SCSP_SRC_EXT_CLK;
        end
    end

    always_comb begin
        wake_target = `SCSP_CK_18;
        rst_dly     = SCSP_DLY_NONE;
        case (nxt_src)
            SCSP_SRC_XTAL: begin
                case ({src_sel_ff[0], sut_ff})
                    3'h0: begin
                        wake_target = `SCSP_CK_258;
                        rst_dly     = SCSP_DLY_SHORT;
                    end
                    3'h1: begin
                        wake_target = `SCSP_CK_258;
                        rst_dly     = SCSP_DLY_LONG;
                    end
                    3'h2: begin
                        wake_target = `SCSP_CK_1K;
                    end
                    3'h3: begin
                        wake_target = `SCSP_CK_1K;
                        rst_dly     = SCSP_DLY_SHORT;
                    end
                    3'h4: begin
                        wake_target = `SCSP_CK_1K;
                        rst_dly     = SCSP_DLY_LONG;
                    end
                    3'h5: begin
                        wake_target = WAKE_16K;
                    end
                    3'h6: begin
                        wake_target = WAKE_16K;
                        rst_dly     = SCSP_DLY_SHORT;
                    end
                    default: begin
                        wake_target = WAKE_16K;
                        rst_dly     = SCSP_DLY_LONG;
                    end
                endcase
            end
            SCSP_SRC_LF_XTAL: begin
                // Reserved code 11 falls back to the safest setting
                wake_target = sut_ff[1] ? WAKE_32K : `SCSP_CK_1K;
                rst_dly     = (sut_ff == 2'h0) ? SCSP_DLY_SHORT
                                               : SCSP_DLY_LONG;
            end
            default: begin
                case (sut_ff)
                    2'h0: rst_dly = SCSP_DLY_NONE;
                    2'h1: rst_dly = SCSP_DLY_SHORT;
                    2'h2: rst_dly = SCSP_DLY_LONG;
                    default: begin
                        wake_target = `SCSP_CK_6;
                        rst_dly     = SCSP_DLY_SHORT;
                    end
                endcase
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [1:0] edge_ff;
    logic       wdt_tick;
    logic       src_tick;
    logic       irq_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            edge_ff  <= 2'h0;
        end else begin
            sync1_ff <= {src_clk_pin, watchdog_oscillator, ext_irq_pin};
            sync2_ff <= sync1_ff;
            edge_ff  <= sync2_ff[2:1];
        end
    end

    assign irq_sync = sync2_ff[0];
    assign wdt_tick = sync2_ff[1] & ~edge_ff[0];
    assign src_tick = sync2_ff[2] & ~edge_ff[1];

    // No flop in this path: a stopped clock cannot hide the request
    assign wake_request = ext_irq_pin;

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic           loop_en_ff;
    logic [1:0]     t1_sel_ff;
    scsp_sleep_type mode_ff;
    logic [7:0]     cal_ff;
    logic [31:0]    prdata_ff;
    logic           wr_en;
    logic           sleep_go;
    logic           addr_ok;
    logic [11:0]    ref_khz;
    logic [13:0]    rc_khz;

    assign wr_en    = psel & penable & pwrite;
    assign sleep_go = wr_en && paddr == `SCSP_OFF_CTRL
                      && pwdata[`SCSP_CTRL_SLEEP_GO];
    assign addr_ok  = paddr == `SCSP_OFF_CTRL || paddr == `SCSP_OFF_CAL
                      || paddr == `SCSP_OFF_STATUS
                      || paddr == `SCSP_OFF_FREQ;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;
    assign prdata   = prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_en_ff <= 1'b0;
            t1_sel_ff  <= 2'h0;
            mode_ff    <= SCSP_SLP_IDLE;
            cal_ff     <= `SCSP_CAL_RESET;
        end else if (wr_en && paddr == `SCSP_OFF_CTRL) begin
            loop_en_ff <= pwdata[`SCSP_CTRL_LOOP_EN];
            t1_sel_ff  <= pwdata[`SCSP_CTRL_T1_HI:`SCSP_CTRL_T1_LO];
            mode_ff    <= scsp_sleep_type'(
                          pwdata[`SCSP_CTRL_MODE_HI:`SCSP_CTRL_MODE_LO]);
        end else if (wr_en && paddr == `SCSP_OFF_CAL) begin
            cal_ff     <= pwdata[7:0];
        end
    end

    // Read data is captured in the setup cycle, so the bus needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                `SCSP_OFF_CTRL: prdata_ff <= {25'h0, mode_ff, 1'b0,
                                              t1_sel_ff, loop_en_ff};
                `SCSP_OFF_CAL: prdata_ff <= {24'h0, cal_ff};
                `SCSP_OFF_STATUS: prdata_ff <= {17'h0, port_b_pin5_crystal,
                                    port_b_pin4_crystal, loop_opt_ff,
                                    sut_ff, src_sel_ff, src_class,
                                    rc_osc_on, loop_running,
                                    loop_locked_flag};
                `SCSP_OFF_FREQ: prdata_ff <= {15'h0, fast_clk_khz};
                default: prdata_ff <= 32'h0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Start-up sequencer
    // ---------------------------------------------------------------
    logic [16:0] cnt_ff;
    logic [16:0] rst_target;
    logic        tick;
    logic        deep;

    assign deep       = mode_ff == SCSP_SLP_POWER_DOWN
                        || mode_ff == SCSP_SLP_STANDBY;
    assign rst_target = (rst_dly == SCSP_DLY_LONG) ? WDT_64K
                                                   : `SCSP_WDT_4K;
    assign tick       = (state_ff == ST_RSTDLY) ? wdt_tick : src_tick;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LATCH: nxt_state = ST_START;
            ST_START: begin
                if (cnt_ff == wake_target) begin
                    nxt_state = (rst_dly == SCSP_DLY_NONE) ? ST_RUN
                                                           : ST_RSTDLY;
                end
            end
            ST_RSTDLY: begin
                if (cnt_ff == rst_target) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_go) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (irq_sync) begin
                    nxt_state = deep ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (cnt_ff == wake_target) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_LATCH;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_LATCH;
            cnt_ff   <= 17'h0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff) begin
                cnt_ff <= 17'h0;
            end else if (tick) begin
                cnt_ff <= cnt_ff + 17'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Domain enables
    // ---------------------------------------------------------------
    // Enables feed latch-based gate cells; a flop output never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cpu_en   <= 1'b0;
            clk_flash_en <= 1'b0;
            clk_io_en    <= 1'b0;
            clk_adc_en   <= 1'b0;
        end else begin
            clk_cpu_en   <= nxt_state == ST_RUN;
            clk_flash_en <= nxt_state == ST_RUN;
            clk_io_en    <= nxt_state == ST_RUN
                            || (nxt_state == ST_SLEEP
                                && mode_ff == SCSP_SLP_IDLE);
            clk_adc_en   <= nxt_state == ST_RUN
                            || (nxt_state == ST_SLEEP && !deep);
        end
    end

    // ---------------------------------------------------------------
    // Loop model
    // ---------------------------------------------------------------
    logic        nxt_loop_run;
    logic [7:0]  lock_cnt_ff;
    logic [7:0]  cal_seen_ff;
    logic [17:0] mult_khz;

    assign rc_khz   = `SCSP_RC_BASE_KHZ
                      + ({6'h0, cal_ff} << `SCSP_RC_STEP_SHIFT);
    assign ref_khz  = rc_khz[13:`SCSP_REF_DIV_SHIFT] + 12'h0;
    assign mult_khz = {ref_khz, 6'h0};
    assign nxt_loop_run = (loop_en_ff || !loop_opt_ff)
                          && !(state_ff == ST_SLEEP && deep);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_osc_on    <= 1'b1;
            loop_running <= 1'b0;
            fast_clk_khz <= 17'h0;
        end else begin
            rc_osc_on    <= !(state_ff == ST_SLEEP && deep);
            loop_running <= nxt_loop_run;
            if (!nxt_loop_run) begin
                fast_clk_khz <= 17'h0;
            end else if (mult_khz > {1'b0, `SCSP_FAST_MAX_KHZ}) begin
                fast_clk_khz <= `SCSP_FAST_MAX_KHZ;
            end else begin
                fast_clk_khz <= mult_khz[16:0];
            end
        end
    end

    // Any retune restarts the lock wait, as a real loop would slip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_ff      <= 8'h0;
            cal_seen_ff      <= `SCSP_CAL_RESET;
            loop_locked_flag <= 1'b0;
        end else begin
            cal_seen_ff <= cal_ff;
            if (!nxt_loop_run || cal_seen_ff != cal_ff
                || ref_khz > `SCSP_REF_NOM_KHZ) begin
                lock_cnt_ff      <= 8'h0;
                loop_locked_flag <= 1'b0;
            end else if (lock_cnt_ff != `SCSP_LOCK_CYCLES) begin
                lock_cnt_ff      <= lock_cnt_ff + 8'h1;
            end else begin
                loop_locked_flag <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Source outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_class           <= SCSP_SRC_INT_RC;
            port_b_pin4_crystal <= 1'b0;
            port_b_pin5_crystal <= 1'b0;
            timer1_clk_sel      <= 2'h0;
        end else begin
            src_class           <= nxt_src;
            port_b_pin4_crystal <= nxt_src != SCSP_SRC_INT_RC
                                   && nxt_src != SCSP_SRC_LOOP;
            port_b_pin5_crystal <= nxt_src == SCSP_SRC_XTAL
                                   || nxt_src == SCSP_SRC_LF_XTAL;
            timer1_clk_sel      <= t1_sel_ff;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    idle_gating_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_SLEEP && mode_ff == SCSP_SLP_IDLE)
        |=> (!clk_cpu_en && clk_io_en) || state_ff != ST_SLEEP)
        else $error("idle sleep gating wrong");
    flash_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_flash_en == clk_cpu_en)
        else $error("flash enable differs from core enable");
    adc_noise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_SLEEP && mode_ff == SCSP_SLP_ADC_NOISE) [*2]
        |-> clk_adc_en && !clk_io_en)
        else $error("converter clock not kept alone");
    fast_nom_a: assert property (@(posedge pclk) disable iff (!presetn)
        (nxt_loop_run && ref_khz == `SCSP_REF_NOM_KHZ)
        |=> fast_clk_khz == 17'h0FA00)
        else $error("fast clock not 64 MHz at nominal");
    fast_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_khz > `SCSP_REF_NOM_KHZ)
        |=> !loop_locked_flag && fast_clk_khz <= `SCSP_FAST_MAX_KHZ)
        else $error("over-range reference kept lock");
    loop_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!loop_en_ff && loop_opt_ff) |=> !loop_running
        || $past(loop_en_ff))
        else $error("loop runs without enable");
    lock_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(loop_locked_flag) |-> $past(lock_cnt_ff) == `SCSP_LOCK_CYCLES)
        else $error("lock flag set before lock wait");
    deep_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_SLEEP && deep) |=> !rc_osc_on && !loop_running)
        else $error("oscillator left on in deep sleep");
    pin_use_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_b_pin5_crystal |-> port_b_pin4_crystal)
        else $error("second crystal pin claimed alone");
    hold_opts_a: assert property (@(posedge pclk) disable iff (!presetn)
        latched_ff |=> $stable(src_sel_ff) && $stable(sut_ff))
        else $error("options changed after latch");
    wake_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAKE && nxt_state == ST_RUN)
        |-> cnt_ff == wake_target)
        else $error("wake left before start-up count");
    reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RSTDLY) |=> !clk_cpu_en || cnt_ff == 17'h0)
        else $error("core ran during reset delay");
endmodule

//--- tb/scsp_osc_model.sv
module scsp_osc_model (
    input  wire logic pclk,
    output logic      src_clk_pin,
    output logic      watchdog_oscillator
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_ff = 3'h0;
    // Eight cycles a period, so the sampling edge detector sees every edge
    always_ff @(posedge pclk) begin
        div_ff <= div_ff + 3'h1;
    end
    assign src_clk_pin         = div_ff[2];
    assign watchdog_oscillator = div_ff[2];
endmodule

//--- tb/system_clock_select_pll_bench.sv
module system_clock_select_pll_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import scsp_pkg::*;
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, pwrite = 1'b0;
    logic        penable = 1'b0, ext_irq_pin = 1'b0, loop_opt = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err, src_clk_pin, watchdog_oscillator;
    logic        wake_request, clk_cpu_en, clk_io_en, clk_flash_en;
    logic        clk_adc_en, rc_osc_on, loop_running, loop_locked_flag;
    logic [16:0] fast_clk_khz;
    logic [1:0]  timer1_clk_sel;
    logic        port_b_pin4_crystal, port_b_pin5_crystal;
    scsp_src_type src_class;
    int          error_cnt = 0, tests_run = 0, cyc = 0, ticks = 0;
    always #20 pclk = ~pclk;
    // Short start-up counts keep the run brief; the 4096 count is untouched
    scsp_clock_ctrl #(.WAKE_16K(17'h00028), .WAKE_32K(17'h0003C),
                      .WDT_64K(17'h00050)) u_scsp_clock_ctrl (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .source_select(4'h1),
        .startup_select(2'h2), .loop_clock_option(loop_opt), .ext_irq_pin,
        .watchdog_oscillator, .src_clk_pin, .wake_request, .clk_cpu_en,
        .clk_io_en, .clk_flash_en, .clk_adc_en, .rc_osc_on, .loop_running,
        .loop_locked_flag, .fast_clk_khz, .timer1_clk_sel,
        .port_b_pin4_crystal, .port_b_pin5_crystal, .src_class);
    scsp_osc_model u_scsp_osc_model (.pclk, .src_clk_pin,
                                     .watchdog_oscillator);
    task automatic chk(input string n, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Idle gap first, so derived frequency registers settle before reads
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        repeat (3) @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wait_cpu();
        cyc = 0;
        while (clk_cpu_en !== 1'b1) begin
            @(negedge pclk);
            cyc++;
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        ticks++;
        if (ticks == 8000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_cpu();
        `CHK("start", 1'b1, cyc > 700 && cyc < 850);
        `CHK("en", 4'hF, {clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en});
        apb(1'b0, 12'h008, 32'h0);
        `CHK("status", 32'h0000184C, q);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("freq_off", 32'h0, q);
        $display("startup test done");
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("freq", 32'hFA00, q);
        `CHK("tsel", 2'h1, timer1_clk_sel);
        repeat (80) @(negedge pclk);
        `CHK("lock", 1'b1, loop_locked_flag);
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("sat", 32'h11170, q);
        `CHK("unlock", 1'b0, loop_locked_flag);
        apb(1'b1, 12'h004, 32'h7F);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("retune", 32'hF900, q);
        apb(1'b1, 12'h004, 32'h80);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("slverr", 1'b1, err);
        `CHK("unmapped", 32'h0, q);
        $display("loop test done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h000, 32'h101 | (m << 4));
            repeat (2) @(negedge pclk);
            `CHK("cpu", 2'h0, {clk_cpu_en, clk_flash_en});
            `CHK("io", m == 0, clk_io_en);
            `CHK("adc", m < 2, clk_adc_en);
            `CHK("rc", {2{m < 2}}, {rc_osc_on, loop_running});
            @(posedge pclk);
            ext_irq_pin <= 1'b1;
            wait_cpu();
            `CHK("irq", 1'b1, wake_request);
            `CHK("wake", m > 1, cyc > 100);
            @(posedge pclk);
            ext_irq_pin <= 1'b0;
        end
        $display("sleep test done");
        // Second power-up with the loop option programmed
        presetn  <= 1'b0;
        loop_opt <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn  <= 1'b1;
        wait_cpu();
        apb(1'b0, 12'h008, 32'h0);
        `CHK("loop_status", 32'h0000086F, q);
        `CHK("loop_class", SCSP_SRC_LOOP, src_class);
        `CHK("loop_pins", 2'h0, {port_b_pin5_crystal, port_b_pin4_crystal});
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("loop_freq", 32'hFA00, q);
        $display("loop option test done");
        conclude();
    end
endmodule
